// ### mtc_pkg.sv
// mtc_pkg: constants for the carrier-side module type check
// assumes a 100 MHz sys_clk and pins already synchronous to it
package mtc_pkg;
   // ****************************************
   // pinout type codes (active-low pins, 1 = open)
   // ****************************************
   localparam logic [2:0] MTC_CODE_TYPE7 = 3'h2;
   localparam int MTC_CODE_BIT0 = 0;
   localparam int MTC_CODE_BIT1 = 1;
   localparam int MTC_CODE_BIT2 = 2;
   // ****************************************
   // revision pin classes
   // ****************************************
   typedef enum logic [1:0] {
      MTC_REV_OPEN = 2'h0,
      MTC_REV_PULLDOWN = 2'h1,
      MTC_REV_HIGHV = 2'h2,
      MTC_REV_BAD = 2'h3
   } mtc_rev_e;
   // ****************************************
   // timing
   // ****************************************
   localparam int MTC_CLK_PERIOD_NS = 10;
   localparam int MTC_STRAP_HOLD_NS = 400;
   localparam int MTC_STRAP_HOLD_CYC =
      (MTC_STRAP_HOLD_NS + MTC_CLK_PERIOD_NS - 1) / MTC_CLK_PERIOD_NS;
   localparam int MTC_CNT_W = 8;
endpackage : mtc_pkg

// ### mtc_rev_decode.sv
// mtc_rev_decode: classes the revision-indicator pin
// assumes a level sense pair: ground detect and high-voltage detect
`timescale 1ns/1ps
module mtc_rev_decode (
   input wire logic rev_low,
   input wire logic rev_highv,
   output mtc_pkg::mtc_rev_e rev_class
);
   wire logic is_open;
   wire logic is_pd;
   wire logic is_hv;
   assign is_open = !rev_low && !rev_highv;
   assign is_pd = rev_low && !rev_highv;
   assign is_hv = !rev_low && rev_highv;
   // open = second gen, pulled down = tenth type, 12 V = first gen
   assign rev_class = is_open ? mtc_pkg::MTC_REV_OPEN :
                      is_pd ? mtc_pkg::MTC_REV_PULLDOWN :
                      is_hv ? mtc_pkg::MTC_REV_HIGHV :
                      mtc_pkg::MTC_REV_BAD;
endmodule : mtc_rev_decode

// ### mtc_carrier.sv
// mtc_carrier: carrier power gating from module type pins, strap hold-off
// assumes pins sampled synchronously to sys_clk; strap pins are tri-state
//
// Function
// - The carrier keeps the main supply off while the type is unsupported.
// - The carrier may light a fault indicator for an incompatible module.
// - The revision pin reads open, pulled down or twelve volts as three kinds.
// - Strap pins stay undriven until 400 ns after resume reset release.
// - The carrier puts no load or pull on the straps during power-up.
`timescale 1ns/1ps
module mtc_carrier #(
   parameter logic [2:0] EXPECTED_CODE = mtc_pkg::MTC_CODE_TYPE7,
   parameter int STRAP_W = 4,
   parameter int HOLD_CYC = mtc_pkg::MTC_STRAP_HOLD_CYC
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic pinout_code_bit0_n,
   input wire logic pinout_code_bit1_n,
   input wire logic pinout_code_bit2_n,
   input wire logic revision_low,
   input wire logic revision_highv,
   input wire logic standby_resume_reset_n,
   input wire logic power_request,
   input wire logic [STRAP_W-1:0] strap_drive_data,
   input wire logic strap_drive_request,
   input wire logic [STRAP_W-1:0] strap_in,
   output logic [STRAP_W-1:0] strap_out,
   output logic [STRAP_W-1:0] strap_oe,
   output logic main_supply_enable,
   output logic type_fault,
   output logic strap_window_open
);
   // ****************************************
   // type and revision decode
   // ****************************************
   wire logic [2:0] code;
   wire logic code_ok;
   wire logic compatible;
   mtc_pkg::mtc_rev_e rev_class;

   // code pins read as pattern; ground = 0, open = 1
   assign code = {pinout_code_bit2_n, pinout_code_bit1_n, pinout_code_bit0_n};
   assign code_ok = (code == EXPECTED_CODE);

   // ****************************************
   // revision pin class
   // ****************************************
   mtc_rev_decode u_rev (
      .rev_low(revision_low),
      .rev_highv(revision_highv),
      .rev_class(rev_class)
   );

   // ****************************************
   // compatibility
   // ****************************************
   // revision pin must read open for the supported generation
   assign compatible = code_ok && (rev_class == mtc_pkg::MTC_REV_OPEN);

   // ****************************************
   // hold-off state machine
   // ****************************************
   typedef enum logic [2:0] {
      MTC_ST_RESET = 3'h1,
      MTC_ST_WAIT = 3'h2,
      MTC_ST_OPEN = 3'h4
   } mtc_state_e;

   mtc_state_e state;
   mtc_state_e next_state;
   logic [mtc_pkg::MTC_CNT_W-1:0] count;
   logic [mtc_pkg::MTC_CNT_W-1:0] next_count;
   wire logic count_done;
   localparam logic [mtc_pkg::MTC_CNT_W-1:0] HOLD_LAST =
      mtc_pkg::MTC_CNT_W'(HOLD_CYC - 1);

   assign count_done = (count == HOLD_LAST);

   always_comb begin
      next_state = state;
      next_count = count;
      unique case (state)
         MTC_ST_RESET: begin
            next_count = '0;
            if (standby_resume_reset_n) begin
               next_state = MTC_ST_WAIT;
            end
         end
         MTC_ST_WAIT: begin
            next_count = count + 1'b1;
            if (!standby_resume_reset_n) begin
               next_state = MTC_ST_RESET;
               next_count = '0;
            end else if (count_done) begin
               // 400 ns counted from release
               next_state = MTC_ST_OPEN;
            end
         end
         MTC_ST_OPEN: begin
            next_count = '0;
            if (!standby_resume_reset_n) begin
               next_state = MTC_ST_RESET;
            end
         end
      endcase
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= MTC_ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************
   // hold-off counter register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   wire logic window;
   wire logic drive_en;
   wire logic next_main_supply_enable;
   wire logic next_type_fault;
   wire logic [STRAP_W-1:0] next_strap_out;
   wire logic [STRAP_W-1:0] next_strap_oe;

   // ****************************************
   // strap window and drive request
   // ****************************************
   // window shuts as soon as resume reset returns
   assign window = (state == MTC_ST_OPEN) && standby_resume_reset_n;
   // straps left floating, no pull, while module samples them
   assign drive_en = window && strap_drive_request;

   // ****************************************
   // supply and fault decode
   // ****************************************
   // supply held off on mismatch
   assign next_main_supply_enable = compatible && power_request;
   // fault lamp on mismatch
   assign next_type_fault = !compatible;

   // ****************************************
   // per-pin strap drive select
   // ****************************************
   generate
      for (genvar i = 0; i < STRAP_W; i++) begin : g_strap
         // idle pins carry 0 so no stale data lingers
         assign next_strap_out[i] = drive_en ? strap_drive_data[i] : 1'b0;
         assign next_strap_oe[i] = drive_en;
      end
   endgenerate

   // ****************************************
   // supply enable register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         main_supply_enable <= 1'b0;
      end else begin
         main_supply_enable <= next_main_supply_enable;
      end
   end

   // ****************************************
   // fault indicator register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         type_fault <= 1'b0;
      end else begin
         type_fault <= next_type_fault;
      end
   end

   // ****************************************
   // window flag register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         strap_window_open <= 1'b0;
      end else begin
         strap_window_open <= window;
      end
   end

   // ****************************************
   // strap output registers
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         strap_out <= '0;
         strap_oe <= '0;
      end else begin
         strap_out <= next_strap_out;
         strap_oe <= next_strap_oe;
      end
   end

   // ****************************************
   // unused inputs
   // ****************************************
   wire logic unused_strap_in;
   assign unused_strap_in = ^strap_in;
endmodule : mtc_carrier

// ### mtc_dev_model.sv
// mtc_dev_model: a seventh-type module's pins as the carrier sees them
// assumes the bench selects a faulty variant only on purpose
`timescale 1ns/1ps
module mtc_dev_model (
   input wire logic bad,
   input wire logic [4:0] bad_pins,
   input wire logic [3:0] strap_out,
   input wire logic [3:0] strap_oe,
   output logic [2:0] code_n,
   output logic rev_low,
   output logic rev_highv,
   output logic [3:0] strap_level
);
   // internal strap pull levels
   localparam logic [3:0] PULL = 4'h5;
   assign code_n = bad ? bad_pins[4:2] : 3'h2;
   assign {rev_low, rev_highv} = bad ? bad_pins[1:0] : 2'h0;
   assign strap_level = (strap_oe & strap_out) | (~strap_oe & PULL);
endmodule : mtc_dev_model

// ### mtc_carrier_asserts.sv
// mtc_carrier_asserts: port checks on mtc_carrier
// assumes it is bound to every mtc_carrier instance
`timescale 1ns/1ps
module mtc_carrier_asserts #(parameter int STRAP_W = 4,
   parameter int HOLD_CYC = 40) (
   input wire logic sys_clk, sys_rst, pinout_code_bit0_n,
   input wire logic pinout_code_bit1_n, pinout_code_bit2_n, revision_low,
   input wire logic revision_highv, standby_resume_reset_n, power_request,
   input wire logic strap_drive_request,
   input wire logic [STRAP_W-1:0] strap_drive_data, strap_out, strap_oe,
   input wire logic main_supply_enable, type_fault, strap_window_open);
   logic ok;
   int cnt;
   assign ok = {pinout_code_bit2_n, pinout_code_bit1_n, pinout_code_bit0_n}
      == 3'h2 && !revision_low && !revision_highv;
   always_ff @(posedge sys_clk)
      cnt <= (sys_rst || !standby_resume_reset_n) ? 0 : cnt + 1;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   supply_off_a: assert property (!ok |=> !main_supply_enable)
      else $error("supply on");
   supply_on_a: assert property (
      ok && power_request && !$past(sys_rst) |=> main_supply_enable)
      else $error("supply off");
   fault_follow_a: assert property (
      !$past(sys_rst) |=> type_fault == !$past(ok)) else $error("fault");
   strap_req_a: assert property ((strap_oe != 0) ==
      (strap_window_open && $past(strap_drive_request))) else $error("oe");
   sequence hold_done_s;
      cnt == HOLD_CYC + 2;
   endsequence
   hold_early_a: assert property (strap_window_open |->
      cnt >= HOLD_CYC + 2 || $past(cnt) >= HOLD_CYC + 2) else $error("early");
   hold_open_a: assert property (hold_done_s |->
      strap_window_open) else $error("late");
   strap_val_a: assert property (strap_oe != 0 |-> strap_oe == '1 &&
      strap_out == $past(strap_drive_data)) else $error("strap value");
   strap_idle_a: assert property (strap_oe == 0 |-> strap_out == 0)
      else $error("strap idle");
endmodule : mtc_carrier_asserts
bind mtc_carrier mtc_carrier_asserts #(.STRAP_W(STRAP_W),
   .HOLD_CYC(HOLD_CYC)) chk (.*);

// ### mtc_carrier_tb.sv
// mtc_carrier_tb: type check and strap hold-off of mtc_carrier
// assumes mtc_dev_model stands for the plugged-in module
`timescale 1ns/1ps
module mtc_carrier_tb;
   localparam int H = 4;
   logic sys_clk = 0, sys_rst = 1, bad = 0, rn = 0, preq = 1, sreq = 1;
   logic [4:0] bp = 0;
   logic [3:0] sd = 4'ha, so, soe, slev;
   logic [2:0] cn;
   logic rl, rh, mse, tf, swo;
   int n_fail = 0, compares = 0, cyc = 0;
   mtc_dev_model dev (.bad(bad), .bad_pins(bp), .strap_out(so),
      .strap_oe(soe), .code_n(cn), .rev_low(rl), .rev_highv(rh),
      .strap_level(slev));
   mtc_carrier #(.HOLD_CYC(H)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .pinout_code_bit0_n(cn[0]), .pinout_code_bit1_n(cn[1]),
      .pinout_code_bit2_n(cn[2]), .revision_low(rl), .revision_highv(rh),
      .standby_resume_reset_n(rn), .power_request(preq),
      .strap_drive_data(sd), .strap_drive_request(sreq), .strap_in(slev),
      .strap_out(so), .strap_oe(soe), .main_supply_enable(mse),
      .type_fault(tf), .strap_window_open(swo));
   task chk(input logic [3:0] seen, input logic [3:0] exp, input string w);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s exp %h seen %h", w, exp, seen);
      end
   endtask : chk
   task give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : give_verdict
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(negedge sys_clk);
      sys_rst = 0;
      repeat (2) @(negedge sys_clk);
      chk(mse, 4'h1, "supply");
      preq = 0;
      @(negedge sys_clk);
      chk(mse, 4'h0, "supply");
      preq = 1;
      bad = 1;
      for (int i = 0; i < 32; i++) begin
         bp = i[4:0];
         @(negedge sys_clk);
         chk(mse, (i == 8) ? 4'h1 : 4'h0, "supply");
         chk(tf, (i == 8) ? 4'h0 : 4'h1, "fault");
      end
      bad = 0;
      $display("test type done");
      rn = 1;
      repeat (H + 1) @(negedge sys_clk);
      chk(soe, 4'h0, "strap oe");
      chk(so, 4'h0, "strap out");
      chk(slev, 4'h5, "strap level");
      @(negedge sys_clk);
      chk(soe, 4'hf, "strap oe");
      chk(so, sd, "strap out");
      chk(slev, sd, "strap level");
      chk(swo, 4'h1, "window");
      sreq = 0;
      @(negedge sys_clk);
      chk(soe, 4'h0, "strap oe");
      sreq = 1;
      rn = 0;
      @(negedge sys_clk);
      chk(soe, 4'h0, "strap oe");
      chk(swo, 4'h0, "window");
      $display("test strap done");
      give_verdict();
   end
endmodule : mtc_carrier_tb
